// file: core/cam_decode_pkg.sv
// Opcode fields, operand encodings and the decoded-operation carrier.
// Assumes a host that presents one 16-bit instruction word per strobe.
package cam_decode_pkg;

  // ************************************************************
  // Instruction word layout
  // ************************************************************
  localparam int INSTR_W = 16;
  localparam int GROUP_HI = 15;
  localparam int GROUP_LO = 8;
  localparam int MASK1_BIT = 6;
  localparam int MASK2_BIT = 7;
  localparam int LOW_HI = 5;
  localparam int LOW_LO = 0;

  // ************************************************************
  // Group codes
  // ************************************************************
  localparam logic [7:0] GRP_PDEST = 8'h01;
  localparam logic [7:0] GRP_PDEST_DIR = 8'h09;
  localparam logic [7:0] GRP_MOVE = 8'h03;
  localparam logic [7:0] GRP_MOVE_DIR = 8'h0b;
  localparam logic [7:0] GRP_VALIDITY = 8'h04;

  // ************************************************************
  // Low-field codes
  // ************************************************************
  localparam logic [5:0] LOW_AT_PTR_BASE = 6'h24;
  localparam logic [5:0] LOW_TOP_VALID = 6'h2c;
  localparam logic [5:0] LOW_VAL_MASK = 6'h3c;
  localparam logic [2:0] DST_KEY = 3'h0;
  localparam logic [2:0] DST_MASK1 = 3'h1;
  localparam logic [2:0] DST_MASK2 = 3'h2;
  localparam logic [2:0] DST_PTR_MEM = 3'h4;
  localparam logic [2:0] DST_VACANT = 3'h6;
  localparam logic [1:0] SRC_MAX = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_PERSIST_DEST, OP_TRANSFER, OP_VALIDITY_SET, OP_ILLEGAL
  } op_kind_e;

  typedef enum logic [2:0] {
    LOC_NONE, LOC_MATCH_KEY, LOC_FIRST_MASK, LOC_SECOND_MASK,
    LOC_ADDRESS_POINTER, LOC_DIRECT_ADDR, LOC_TOP_MATCH_SLOT, LOC_NEXT_VACANT_SLOT
  } loc_e;

  typedef enum logic [1:0] {
    MSK_NONE, MSK_FIRST, MSK_SECOND
  } mask_sel_e;

  // Skip bit above empty bit: valid, empty, skip, random access.
  typedef enum logic [1:0] {
    VAL_VALID, VAL_EMPTY, VAL_SKIP, VAL_RANDOM
  } validity_e;

  typedef struct packed {
    op_kind_e kind;
    loc_e dst;
    loc_e src;
    mask_sel_e mask;
    validity_e validity;
    logic set_validity;
  } decoded_s;

endpackage

// file: core/cam_instruction_decoder.sv
// Decoder that turns host instruction words into internal CAM operations.
// Assumes instr_valid is a one-cycle strobe synchronous to clk.
`timescale 1ns/1ps

// Overview of operation
// - 0124/0164/01A4: pointer entry valid destination
// - 0127/0167/01A7: pointer entry random destination
// - 0924/0964/09A4: direct entry valid destination
// - 0925/0965/09A5: direct entry empty destination
// - 0926/0966/09A6: direct entry skip destination
// - 0927/0967/09A7: direct entry random destination
// - 012C/016C/01AC: top match valid destination
// - 0304/0344/0384: key from pointer entry
// - 0305/0345/0385: key from top match
// - First mask loads; 0309 is no operation
// - Second mask loads; 0312 is no operation
// - Pointer entry writes, optional valid mark
// - Next vacant entry writes, optional valid mark
// - 0424-0427 set pointer entry validity
module cam_instruction_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [cam_decode_pkg::INSTR_W-1:0] instr,
  output logic op_valid,
  output cam_decode_pkg::decoded_s op
);

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic cam_decode_pkg::loc_e reg_loc(input logic [1:0] idx);
    reg_loc = (idx == 2'h0) ? cam_decode_pkg::LOC_MATCH_KEY :
              (idx == 2'h1) ? cam_decode_pkg::LOC_FIRST_MASK :
                              cam_decode_pkg::LOC_SECOND_MASK;
  endfunction

  function automatic cam_decode_pkg::decoded_s decode(
    input logic [cam_decode_pkg::INSTR_W-1:0] w);
    cam_decode_pkg::decoded_s d;
    logic [7:0] grp;
    logic [5:0] low;
    logic [2:0] dsel;
    logic maskable;
    d = '0;
    grp = w[cam_decode_pkg::GROUP_HI:cam_decode_pkg::GROUP_LO];
    low = w[cam_decode_pkg::LOW_HI:cam_decode_pkg::LOW_LO];
    dsel = low[5:3];
    maskable = 1'b0;
    d.kind = cam_decode_pkg::OP_ILLEGAL;
    d.mask = cam_decode_pkg::MSK_NONE;
    // Both select bits together name no mask and are refused.
    if (w[cam_decode_pkg::MASK1_BIT]) begin
      d.mask = cam_decode_pkg::MSK_FIRST;
    end else if (w[cam_decode_pkg::MASK2_BIT]) begin
      d.mask = cam_decode_pkg::MSK_SECOND;
    end
    d.validity = cam_decode_pkg::validity_e'(low[1:0]);
    if (grp == cam_decode_pkg::GRP_PDEST || grp == cam_decode_pkg::GRP_PDEST_DIR) begin
      maskable = 1'b1;
      d.set_validity = 1'b1;
      if ((low & cam_decode_pkg::LOW_VAL_MASK) == cam_decode_pkg::LOW_AT_PTR_BASE) begin
        d.kind = cam_decode_pkg::OP_PERSIST_DEST;
        d.dst = (grp == cam_decode_pkg::GRP_PDEST) ? cam_decode_pkg::LOC_ADDRESS_POINTER :
                                                     cam_decode_pkg::LOC_DIRECT_ADDR;
        // Empty and skip at the pointer belong to neighbouring text and stay refused.
        if (grp == cam_decode_pkg::GRP_PDEST &&
            (d.validity == cam_decode_pkg::VAL_EMPTY || d.validity == cam_decode_pkg::VAL_SKIP)) begin
          d.kind = cam_decode_pkg::OP_ILLEGAL;
        end
      end else if (low == cam_decode_pkg::LOW_TOP_VALID && grp == cam_decode_pkg::GRP_PDEST) begin
        d.kind = cam_decode_pkg::OP_PERSIST_DEST;
        d.dst = cam_decode_pkg::LOC_TOP_MATCH_SLOT;
        d.validity = cam_decode_pkg::VAL_VALID;
      end
    end else if (grp == cam_decode_pkg::GRP_MOVE || grp == cam_decode_pkg::GRP_MOVE_DIR) begin
      d.kind = cam_decode_pkg::OP_TRANSFER;
      if (dsel <= cam_decode_pkg::DST_MASK2) begin
        d.dst = reg_loc(dsel[1:0]);
        if (low[2]) begin
          // Direct-address source exists only under the 0B prefix.
          if (grp == cam_decode_pkg::GRP_MOVE_DIR) begin
            d.src = cam_decode_pkg::LOC_DIRECT_ADDR;
            if (low[1:0] != 2'h0) d.kind = cam_decode_pkg::OP_ILLEGAL;
          end else begin
            d.src = low[0] ? cam_decode_pkg::LOC_TOP_MATCH_SLOT :
                             cam_decode_pkg::LOC_ADDRESS_POINTER;
            if (low[1]) d.kind = cam_decode_pkg::OP_ILLEGAL;
          end
          maskable = (dsel == cam_decode_pkg::DST_KEY);
        end else if (grp == cam_decode_pkg::GRP_MOVE_DIR || low[1:0] > cam_decode_pkg::SRC_MAX) begin
          d.kind = cam_decode_pkg::OP_ILLEGAL;
        end else if (low[1:0] == dsel[1:0]) begin
          d.kind = cam_decode_pkg::OP_NONE;
        end else begin
          d.src = reg_loc(low[1:0]);
        end
      end else if ((dsel == cam_decode_pkg::DST_PTR_MEM || dsel == cam_decode_pkg::DST_VACANT) &&
                   grp == cam_decode_pkg::GRP_MOVE && low[1:0] <= cam_decode_pkg::SRC_MAX) begin
        d.dst = (dsel == cam_decode_pkg::DST_PTR_MEM) ? cam_decode_pkg::LOC_ADDRESS_POINTER :
                                                        cam_decode_pkg::LOC_NEXT_VACANT_SLOT;
        d.src = reg_loc(low[1:0]);
        d.set_validity = low[2];
        d.validity = cam_decode_pkg::VAL_VALID;
        maskable = (low[1:0] == 2'h0) && !low[2];
      end else begin
        d.kind = cam_decode_pkg::OP_ILLEGAL;
      end
    end else if (grp == cam_decode_pkg::GRP_VALIDITY &&
                 (low & cam_decode_pkg::LOW_VAL_MASK) == cam_decode_pkg::LOW_AT_PTR_BASE) begin
      d.kind = cam_decode_pkg::OP_VALIDITY_SET;
      d.dst = cam_decode_pkg::LOC_ADDRESS_POINTER;
      d.set_validity = 1'b1;
    end
    if (w[cam_decode_pkg::MASK1_BIT] && w[cam_decode_pkg::MASK2_BIT]) begin
      d.kind = cam_decode_pkg::OP_ILLEGAL;
    end
    if (d.mask != cam_decode_pkg::MSK_NONE && !maskable) begin
      d.kind = cam_decode_pkg::OP_ILLEGAL;
    end
    if (d.kind == cam_decode_pkg::OP_ILLEGAL || d.kind == cam_decode_pkg::OP_NONE) begin
      d = '{kind: d.kind, dst: cam_decode_pkg::LOC_NONE, src: cam_decode_pkg::LOC_NONE,
            mask: cam_decode_pkg::MSK_NONE, validity: cam_decode_pkg::VAL_VALID,
            set_validity: 1'b0};
    end
    decode = d;
  endfunction

  // ************************************************************
  // Output register
  // ************************************************************
  cam_decode_pkg::decoded_s op_d;
  cam_decode_pkg::decoded_s op_q;
  logic valid_d;
  logic valid_q;

  // The last decode is held so the executing logic may sample it late.
  always_comb begin
    op_d = op_q;
    valid_d = instr_valid;
    if (instr_valid) begin
      op_d = decode(instr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= '0;
      valid_q <= 1'b0;
    end else begin
      op_q <= op_d;
      valid_q <= valid_d;
    end
  end

  assign op = op_q;
  assign op_valid = valid_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_issued(logic [15:0] code);
    instr_valid && instr == code;
  endsequence

  a_ptr_valid_dest: assert property (s_issued(16'h0164) |=> op_valid &&
    op.kind == cam_decode_pkg::OP_PERSIST_DEST && op.dst == cam_decode_pkg::LOC_ADDRESS_POINTER &&
    op.mask == cam_decode_pkg::MSK_FIRST && op.validity == cam_decode_pkg::VAL_VALID)
    else $error("pointer valid destination misdecoded");
  a_ptr_random_dest: assert property (s_issued(16'h01a7) |=>
    op.kind == cam_decode_pkg::OP_PERSIST_DEST && op.mask == cam_decode_pkg::MSK_SECOND &&
    op.validity == cam_decode_pkg::VAL_RANDOM)
    else $error("pointer random destination misdecoded");
  a_direct_skip_dest: assert property (s_issued(16'h0966) |=>
    op.dst == cam_decode_pkg::LOC_DIRECT_ADDR && op.validity == cam_decode_pkg::VAL_SKIP)
    else $error("direct skip destination misdecoded");
  a_top_match_dest: assert property (s_issued(16'h01ac) |=>
    op.dst == cam_decode_pkg::LOC_TOP_MATCH_SLOT && op.mask == cam_decode_pkg::MSK_SECOND)
    else $error("top match destination misdecoded");
  a_key_from_top: assert property (s_issued(16'h0345) |=>
    op.kind == cam_decode_pkg::OP_TRANSFER && op.dst == cam_decode_pkg::LOC_MATCH_KEY &&
    op.src == cam_decode_pkg::LOC_TOP_MATCH_SLOT && op.mask == cam_decode_pkg::MSK_FIRST)
    else $error("key from top match misdecoded");
  a_self_move_nop: assert property (s_issued(16'h0309) |=> op_valid &&
    op.kind == cam_decode_pkg::OP_NONE && op.dst == cam_decode_pkg::LOC_NONE &&
    op.src == cam_decode_pkg::LOC_NONE && !op.set_validity)
    else $error("self move not a no operation");
  a_mask2_direct: assert property (s_issued(16'h0b14) |=>
    op.dst == cam_decode_pkg::LOC_SECOND_MASK && op.src == cam_decode_pkg::LOC_DIRECT_ADDR)
    else $error("second mask direct load misdecoded");
  a_vacant_mark: assert property (s_issued(16'h0336) |=>
    op.dst == cam_decode_pkg::LOC_NEXT_VACANT_SLOT && op.set_validity &&
    op.src == cam_decode_pkg::LOC_SECOND_MASK)
    else $error("vacant slot write misdecoded");
  a_validity_set: assert property (s_issued(16'h0425) |=>
    op.kind == cam_decode_pkg::OP_VALIDITY_SET && op.validity == cam_decode_pkg::VAL_EMPTY)
    else $error("validity set misdecoded");
  a_direct_valid_dest: assert property (s_issued(16'h0924) |=>
    op.kind == cam_decode_pkg::OP_PERSIST_DEST && op.dst == cam_decode_pkg::LOC_DIRECT_ADDR &&
    op.mask == cam_decode_pkg::MSK_NONE && op.validity == cam_decode_pkg::VAL_VALID)
    else $error("direct valid destination misdecoded");
  a_direct_empty_dest: assert property (s_issued(16'h09a5) |=>
    op.dst == cam_decode_pkg::LOC_DIRECT_ADDR && op.mask == cam_decode_pkg::MSK_SECOND &&
    op.validity == cam_decode_pkg::VAL_EMPTY && op.set_validity)
    else $error("direct empty destination misdecoded");
  a_direct_random_dest: assert property (s_issued(16'h0967) |=>
    op.dst == cam_decode_pkg::LOC_DIRECT_ADDR && op.mask == cam_decode_pkg::MSK_FIRST &&
    op.validity == cam_decode_pkg::VAL_RANDOM)
    else $error("direct random destination misdecoded");
  a_key_from_ptr: assert property (s_issued(16'h0384) |=>
    op.kind == cam_decode_pkg::OP_TRANSFER && op.dst == cam_decode_pkg::LOC_MATCH_KEY &&
    op.src == cam_decode_pkg::LOC_ADDRESS_POINTER && op.mask == cam_decode_pkg::MSK_SECOND)
    else $error("key from pointer entry misdecoded");
  a_key_from_mask: assert property (s_issued(16'h0302) |=>
    op.kind == cam_decode_pkg::OP_TRANSFER && op.dst == cam_decode_pkg::LOC_MATCH_KEY &&
    op.src == cam_decode_pkg::LOC_SECOND_MASK)
    else $error("key from second mask misdecoded");
  a_ptr_write_masked: assert property (s_issued(16'h0360) |=>
    op.dst == cam_decode_pkg::LOC_ADDRESS_POINTER && op.src == cam_decode_pkg::LOC_MATCH_KEY &&
    op.mask == cam_decode_pkg::MSK_FIRST && !op.set_validity)
    else $error("pointer entry write misdecoded");
  a_both_masks_refused: assert property (instr_valid &&
    instr[cam_decode_pkg::MASK1_BIT] && instr[cam_decode_pkg::MASK2_BIT] |=>
    op_valid && op.kind == cam_decode_pkg::OP_ILLEGAL && op.mask == cam_decode_pkg::MSK_NONE)
    else $error("both mask selects not refused");
  a_hold_idle: assert property (!instr_valid |=> !op_valid && $stable(op))
    else $error("decode changed without a strobe");

endmodule // cam_instruction_decoder

// file: bench/cam_host_model.sv
// Host model that presents instruction words to the decoder.
// Assumes one bench process calls its tasks, never two in one time step.
`timescale 1ns/1ps
module cam_host_model (
  input wire logic clk,
  output logic instr_valid,
  output logic [cam_decode_pkg::INSTR_W-1:0] instr
);
  // ************************************************************
  // Word delivery
  // ************************************************************
  initial begin
    instr_valid = 1'b0;
    instr = 16'h0000;
  end

  // Words change at the falling edge, half a period clear of sampling.
  task automatic issue(input logic [15:0] w);
    @(negedge clk);
    instr_valid <= 1'b1;
    instr <= w;
  endtask

  // An idle bus carries junk, so a decoder that ignores the strobe is caught.
  task automatic idle(input logic [15:0] junk);
    @(negedge clk);
    instr_valid <= 1'b0;
    instr <= junk;
  endtask
endmodule // cam_host_model

// file: bench/cam_instruction_decoder_test.sv
// Self-checking bench for the instruction decoder.
// Assumes the host model drives the strobe and word at the falling edge.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module cam_instruction_decoder_test;
  // ************************************************************
  // Harness
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid;
  logic [15:0] instr;
  logic op_valid;
  cam_decode_pkg::decoded_s op;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h000021b5;
  cam_decode_pkg::decoded_s exp_q[$];
  int due_q[$];

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  cam_host_model i_cam_host_model (.clk(clk), .instr_valid(instr_valid), .instr(instr));
  cam_instruction_decoder i_cam_instruction_decoder (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr(instr), .op_valid(op_valid), .op(op));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Codes follow the package enum order: kind k, locations d and s, validity v.
  // Register-to-register moves carry the low source code in the unused validity field.
  task automatic send(input logic [15:0] w, input int k, d, s, v, sv);
    cam_decode_pkg::decoded_s e;
    logic [31:0] r;
    e.kind = cam_decode_pkg::op_kind_e'(k);
    e.dst = cam_decode_pkg::loc_e'(d);
    e.src = cam_decode_pkg::loc_e'(s);
    e.mask = cam_decode_pkg::mask_sel_e'((k == 1 || k == 2) ? w[7:6] : 2'h0);
    e.validity = cam_decode_pkg::validity_e'(v);
    e.set_validity = sv[0];
    i_cam_host_model.issue(w);
    exp_q.push_back(e);
    due_q.push_back(cyc + 1);
    r = xs();
    if (r[0]) i_cam_host_model.idle(r[31:16]);
  endtask

  task automatic send3(input logic [15:0] w, input int k, d, s, v, sv);
    send(w, k, d, s, v, sv);
    send(w | 16'h0040, k, d, s, v, sv);
    send(w | 16'h0080, k, d, s, v, sv);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ************************************************************
  // Result watcher
  // ************************************************************
  always @(negedge clk) begin
    if (op_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1, "op_valid without a request")
      if (exp_q.size() > 0) begin
        `CHK(cyc, due_q.pop_front(), "op_valid latency")
        `CHK(op, exp_q.pop_front(), "decoded fields")
      end
    end
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    `CHK(op, '0, "op after reset")
    send3(16'h0124, 1, 4, 0, 0, 1);
    send3(16'h0127, 1, 4, 0, 3, 1);
    send(16'h0125, 4, 0, 0, 0, 0);
    send(16'h0126, 4, 0, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      send3(16'(16'h0924 + i), 1, 5, 0, i, 1);
    end
    send3(16'h012c, 1, 6, 0, 0, 1);
    send3(16'h0304, 2, 1, 4, 0, 0);
    send3(16'h0305, 2, 1, 6, 1, 0);
    send(16'h0300, 0, 0, 0, 0, 0);
    send(16'h0301, 2, 1, 2, 1, 0);
    send(16'h0302, 2, 1, 3, 2, 0);
    send(16'h0308, 2, 2, 1, 0, 0);
    send(16'h0309, 0, 0, 0, 0, 0);
    send(16'h030a, 2, 2, 3, 2, 0);
    send(16'h030c, 2, 2, 4, 0, 0);
    send(16'h0b0c, 2, 2, 5, 0, 0);
    send(16'h030d, 2, 2, 6, 1, 0);
    send(16'h0310, 2, 3, 1, 0, 0);
    send(16'h0311, 2, 3, 2, 1, 0);
    send(16'h0312, 0, 0, 0, 0, 0);
    send(16'h0314, 2, 3, 4, 0, 0);
    send(16'h0b14, 2, 3, 5, 0, 0);
    send(16'h0315, 2, 3, 6, 1, 0);
    send3(16'h0320, 2, 4, 1, 0, 0);
    send(16'h0321, 2, 4, 2, 0, 0);
    send3(16'h0330, 2, 7, 1, 0, 0);
    for (int i = 1; i < 3; i++) send(16'(16'h0330 + i), 2, 7, 1 + i, 0, 0);
    for (int i = 0; i < 3; i++) send(16'(16'h0334 + i), 2, 7, 1 + i, 0, 1);
    send(16'h0b04, 2, 1, 5, 0, 0);
    send(16'h0341, 4, 0, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      send(r[15:0] | 16'h00c0, 4, 0, 0, 0, 0);
    end
    for (int i = 0; i < 4; i++) send(16'(16'h0424 + i), 3, 4, 0, i, 1);
    i_cam_host_model.idle(16'h0124);
    repeat (3) @(negedge clk);
    `CHK(exp_q.size(), 0, "results missing")
    // A reset in mid-run must clear a held decode at once, not at the next edge.
    rst_n <= 1'b0;
    #1;
    `CHK({op_valid, op}, '0, "op during reset")
    @(negedge clk);
    rst_n <= 1'b1;
    send(16'h0427, 3, 4, 0, 3, 1);
    i_cam_host_model.idle(16'h0000);
    repeat (3) @(negedge clk);
    `CHK(exp_q.size(), 0, "results missing")
    print_verdict();
  end
endmodule // cam_instruction_decoder_test
